// ===== rtl/mic_ctrl.v
// Purpose: multilevel interrupt controller with apb register access
// Assumes: requests and cpu handshake are on clk; one-hot style request
//          vector indexed by vector number
// Notes:   ack is a one-cycle pulse carrying the winning vector number
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "mic_consts.vh"

// Overview of operation
// - pick winner by level first, then by priority inside the level
// - high, medium and nmi always fixed; only low may rotate
// - fixed priority: lowest vector number wins within a level
// - rotating: last acknowledged low vector gets lowest priority next
// - status bit 7 set while nmi handler runs, cleared by its return
// - status bits 6 to 3 always read zero
// - status bit 2 held while high handler runs or is preempted
// - status bit 1 held while medium handler runs or is preempted
// - status bit 0 held while low handler runs or is preempted
// - rotating mode captures acked low vector; software may write it
// - last vector kept when rotation turns off; software clears it
// - control bit 7 selects rotating low scheduling, else fixed
// - control bit 6 picks boot or application vector table
// - vector table select writable only in protection window
// - control bit 2 enables high level requests
// - control bit 1 enables medium level requests
// - control bit 0 enables low level requests
// - level code per request: 00 off, 01 low, 10 medium, 11 high
// - higher level preempts lower level handler
// - nmi served regardless of global enable; nothing preempts nmi
// - handler return restores prior level state
module mic_ctrl #(
    parameter NVEC = 32
) (
    // clock and reset
    input  wire             clk,
    input  wire             rstn,
    input  wire             clk_en,
    // apb slave
    input  wire             psel,
    input  wire             penable,
    input  wire             pwrite,
    input  wire [11:0]      paddr,
    input  wire [31:0]      pwdata,
    output reg  [31:0]      prdata,
    output reg              pready,
    output reg              pslverr,
    // peripheral requests
    input  wire [NVEC-1:0]  irq_req,
    input  wire [2*NVEC-1:0] irq_level,
    input  wire [NVEC-1:0]  nmi_req,
    // cpu side
    input  wire             global_ie,
    input  wire             cpu_ready,
    input  wire             handler_return_instr,
    output reg              irq_ack,
    output reg  [7:0]       irq_vector,
    output reg              vector_location,
    output reg  [7:0]       level_status
);

    // control, last vector and status state
    reg [7:0] ctrl;
    reg [7:0] last_low_vector;
    reg       nonmaskable_running_flag;
    reg       high_running_flag;
    reg       medium_running_flag;
    reg       low_running_flag;
    reg [2:0] ccp_cnt;

    wire rotating_sched_enable = ctrl[`MIC_CT_RR];
    wire high_level_enable     = ctrl[`MIC_CT_HIEN];
    wire medium_level_enable   = ctrl[`MIC_CT_MEDEN];
    wire low_level_enable      = ctrl[`MIC_CT_LOEN];

    // lowest set index of a vector, with found flag in bit 8
    function [8:0] first_set;
        input [NVEC-1:0] v;
        integer i;
        begin
            first_set = 9'h000;
            for (i = NVEC - 1; i >= 0; i = i - 1) begin
                if (v[i]) begin
                    first_set = {1'b1, i[7:0]};
                end
            end
        end
    endfunction

    // per-level pending masks, gated by level enables
    reg [NVEC-1:0] pend_hi;
    reg [NVEC-1:0] pend_med;
    reg [NVEC-1:0] pend_lo;
    reg [NVEC-1:0] pend_lo_after;
    integer k;
    always @* begin
        pend_hi       = {NVEC{1'b0}};
        pend_med      = {NVEC{1'b0}};
        pend_lo       = {NVEC{1'b0}};
        pend_lo_after = {NVEC{1'b0}};
        for (k = 0; k < NVEC; k = k + 1) begin
            if (irq_req[k]) begin
                case (irq_level[2*k +: 2])
                    `MIC_LVL_HI:  pend_hi[k]  = high_level_enable;
                    `MIC_LVL_MED: pend_med[k] = medium_level_enable;
                    `MIC_LVL_LO:  pend_lo[k]  = low_level_enable;
                    default:      pend_lo[k]  = 1'b0;
                endcase
            end
            if (k > last_low_vector) begin
                pend_lo_after[k] = pend_lo[k];
            end
        end
    end

    // arbitration: nmi, then high, medium, low; lowest vector wins unless low rotates
    wire [8:0] win_nmi = first_set(nmi_req);
    wire [8:0] win_hi  = first_set(pend_hi);
    wire [8:0] win_med = first_set(pend_med);
    wire [8:0] win_lo_fix = first_set(pend_lo);
    wire [8:0] win_lo_rot = first_set(pend_lo_after);
    // rotating: search above last vector first, then wrap around
    wire [8:0] win_lo = (rotating_sched_enable && win_lo_rot[8]) ?
                        win_lo_rot : win_lo_fix;

    reg       next_ack;
    reg [7:0] next_vec;
    reg [1:0] next_kind;
    always @* begin
        next_ack  = 1'b0;
        next_vec  = 8'h00;
        next_kind = `MIC_LVL_OFF;
        if (cpu_ready && !irq_ack && !nonmaskable_running_flag) begin
            if (win_nmi[8]) begin
                next_ack  = 1'b1;
                next_vec  = win_nmi[7:0];
                next_kind = `MIC_LVL_OFF;
            end else if (global_ie && (ccp_cnt == 3'h0)) begin
                if (win_hi[8] && !high_running_flag) begin
                    next_ack  = 1'b1;
                    next_vec  = win_hi[7:0];
                    next_kind = `MIC_LVL_HI;
                end else if (win_med[8] && !high_running_flag &&
                             !medium_running_flag) begin
                    next_ack  = 1'b1;
                    next_vec  = win_med[7:0];
                    next_kind = `MIC_LVL_MED;
                end else if (win_lo[8] && !high_running_flag &&
                             !medium_running_flag &&
                             !low_running_flag) begin
                    next_ack  = 1'b1;
                    next_vec  = win_lo[7:0];
                    next_kind = `MIC_LVL_LO;
                end
            end
        end
    end

    // apb decode
    wire apb_acc  = psel && penable && pready;
    wire apb_wr   = apb_acc && pwrite;
    wire addr_ok  = (paddr == `MIC_ADDR_STATUS) ||
                    (paddr == `MIC_ADDR_LASTVEC) ||
                    (paddr == `MIC_ADDR_CTRL) ||
                    (paddr == `MIC_ADDR_CCP);
    wire [7:0] status_word = {nonmaskable_running_flag, 4'h0,
                              high_running_flag, medium_running_flag,
                              low_running_flag};

    // apb handshake: no wait state, error on unmapped address
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (clk_en) begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !addr_ok;
            prdata  <= 32'h0000_0000;
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    `MIC_ADDR_STATUS:  prdata <= {24'h0, status_word};
                    `MIC_ADDR_LASTVEC: prdata <= {24'h0, last_low_vector};
                    `MIC_ADDR_CTRL:    prdata <= {24'h0, ctrl};
                    default:           prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // control register and protection window
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl    <= `MIC_RST_CTRL;
            ccp_cnt <= 3'h0;
        end else if (clk_en) begin
            if (ccp_cnt != 3'h0) begin
                ccp_cnt <= ccp_cnt - 3'h1;
            end
            if (apb_wr && paddr == `MIC_ADDR_CCP &&
                pwdata[7:0] == `MIC_CCP_KEY) begin
                ccp_cnt <= `MIC_CCP_CYCLES;
            end
            if (apb_wr && paddr == `MIC_ADDR_CTRL) begin
                ctrl[`MIC_CT_RR]    <= pwdata[`MIC_CT_RR];
                ctrl[`MIC_CT_HIEN]  <= pwdata[`MIC_CT_HIEN];
                ctrl[`MIC_CT_MEDEN] <= pwdata[`MIC_CT_MEDEN];
                ctrl[`MIC_CT_LOEN]  <= pwdata[`MIC_CT_LOEN];
                if (ccp_cnt != 3'h0) begin
                    ctrl[`MIC_CT_VECTOR_TABLE_SELECT] <= pwdata[`MIC_CT_VECTOR_TABLE_SELECT];
                end
            end
        end
    end

    // last acknowledged low vector; hardware capture beats software write
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            last_low_vector <= `MIC_RST_LASTVEC;
        end else if (clk_en) begin
            if (next_ack && next_kind == `MIC_LVL_LO &&
                rotating_sched_enable) begin
                last_low_vector <= next_vec;
            end else if (apb_wr && paddr == `MIC_ADDR_LASTVEC) begin
                last_low_vector <= pwdata[7:0];
            end
        end
    end

    // level tracking: ack sets, return clears the highest active level
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            nonmaskable_running_flag <= 1'b0;
            high_running_flag        <= 1'b0;
            medium_running_flag      <= 1'b0;
            low_running_flag         <= 1'b0;
        end else if (clk_en) begin
            if (handler_return_instr) begin
                if (nonmaskable_running_flag) begin
                    nonmaskable_running_flag <= 1'b0;
                end else if (high_running_flag) begin
                    high_running_flag <= 1'b0;
                end else if (medium_running_flag) begin
                    medium_running_flag <= 1'b0;
                end else begin
                    low_running_flag <= 1'b0;
                end
            end else if (next_ack) begin
                case (next_kind)
                    `MIC_LVL_OFF: nonmaskable_running_flag <= 1'b1;
                    `MIC_LVL_HI:  high_running_flag   <= 1'b1;
                    `MIC_LVL_MED: medium_running_flag <= 1'b1;
                    `MIC_LVL_LO:  low_running_flag    <= 1'b1;
                    default:      low_running_flag    <= low_running_flag;
                endcase
            end
        end
    end

    // acknowledge pulse and registered status outputs
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq_ack         <= 1'b0;
            irq_vector      <= 8'h00;
            vector_location <= 1'b0;
            level_status    <= `MIC_RST_STATUS;
        end else if (clk_en) begin
            irq_ack         <= next_ack && !handler_return_instr;
            irq_vector      <= next_ack ? next_vec : irq_vector;
            vector_location <= ctrl[`MIC_CT_VECTOR_TABLE_SELECT];
            level_status    <= status_word;
        end
    end

endmodule
`default_nettype wire

// ===== rtl/mic_consts.vh
// Purpose: constants of the multilevel interrupt controller
// Assumes: included by the controller design file and the bench
// Notes:   register offsets are byte addresses on a 32-bit apb bus
`ifndef MIC_CONSTS_VH
`define MIC_CONSTS_VH

// register indices and byte addresses (address = 4 * index)
`define MIC_IDX_STATUS     2'h0
`define MIC_IDX_LASTVEC    2'h1
`define MIC_IDX_CTRL       2'h2
`define MIC_ADDR_STATUS    12'h000
`define MIC_ADDR_LASTVEC   12'h004
`define MIC_ADDR_CTRL      12'h008
`define MIC_ADDR_CCP       12'h00c

// configuration change protection
`define MIC_CCP_KEY        8'hd8
`define MIC_CCP_CYCLES     3'h4

// status fields
`define MIC_ST_NMI         7
`define MIC_ST_HI          2
`define MIC_ST_MED         1
`define MIC_ST_LO          0

// control fields
`define MIC_CT_RR          7
`define MIC_CT_VECTOR_TABLE_SELECT       6
`define MIC_CT_HIEN        2
`define MIC_CT_MEDEN       1
`define MIC_CT_LOEN        0
`define MIC_CTRL_WMASK     8'h87

// level codes
`define MIC_LVL_OFF        2'h0
`define MIC_LVL_LO         2'h1
`define MIC_LVL_MED        2'h2
`define MIC_LVL_HI         2'h3

// reset values
`define MIC_RST_STATUS     8'h00
`define MIC_RST_LASTVEC    8'h00
`define MIC_RST_CTRL       8'h00

`endif

// ===== test/mic_cpu_model.sv
// Purpose: cpu core model facing the interrupt controller
// Assumes: one instruction runs after every acknowledge
// Notes:   return pulse follows the bench's ret_go by one cycle
`timescale 1ns/1ps
`default_nettype none
module mic_cpu_model (
    // clock and reset
    input  wire logic clk,
    input  wire logic rstn,
    // controller side
    input  wire logic irq_ack,
    input  wire logic ret_go,
    output var  logic cpu_ready,
    output var  logic handler_return_instr
);
    // not ready in the cycle after an acknowledge; return on request
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cpu_ready            <= 1'b0;
            handler_return_instr <= 1'b0;
        end else begin
            cpu_ready            <= !irq_ack;
            handler_return_instr <= ret_go;
        end
    end
endmodule
`default_nettype wire

// ===== test/mic_ctrl_assertions.sv
// Purpose: port-level assertions for the interrupt controller
// Assumes: single clock, asynchronous active-low reset
// Notes:   level_status trails the internal flags by one cycle
`timescale 1ns/1ps
`default_nettype none
module mic_ctrl_chk #(
    parameter NVEC = 32
) (
    // apb side
    input wire logic            clk, rstn, psel, penable, pready, pslverr,
    input wire logic [11:0]     paddr,
    input wire logic [31:0]     prdata,
    // requests and cpu side
    input wire logic [NVEC-1:0] irq_req, nmi_req,
    input wire logic            handler_return_instr, irq_ack,
    input wire logic [7:0]      irq_vector, level_status
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // a return with no acknowledge landing beside it
    sequence s_ret_clean;
        handler_return_instr && !irq_ack;
    endsequence
    // acknowledge of a non-maskable request
    sequence s_nmi_ack;
        irq_ack && ((($past(nmi_req) >> irq_vector) & 1) != 0);
    endsequence
    a_status_reserved: assert property (level_status[6:3] == 4'h0)
        else $error("status reserved bits set");
    a_ack_single: assert property (irq_ack |=> !irq_ack)
        else $error("acknowledge longer than one cycle");
    a_ack_pending: assert property (
        irq_ack |-> ((($past(irq_req | nmi_req)) >> irq_vector) & 1) != 0)
        else $error("acknowledged vector was not pending");
    a_nmi_blocks: assert property (
        level_status[7] && !handler_return_instr
        && !$past(handler_return_instr) |=> !irq_ack)
        else $error("acknowledge while nmi handler runs");
    a_nmi_flag: assert property (s_nmi_ack |=> level_status[7])
        else $error("nmi flag not set after nmi acknowledge");
    a_ret_nmi: assert property (
        s_ret_clean ##0 level_status[7] |-> ##2 !level_status[7])
        else $error("nmi flag not cleared by return");
    a_ret_high: assert property (
        s_ret_clean ##0 level_status[7:2] == 6'h01
        |-> ##2 level_status == {6'h00, $past(level_status[1:0], 2)})
        else $error("high return did not restore lower flags");
    a_apb_answer: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("apb answer not in the access cycle");
    a_apb_error: assert property (
        pready |-> (pslverr == (paddr > 12'h00c)) && prdata[31:8] == 24'h0)
        else $error("apb error or upper read data wrong");
endmodule
bind mic_ctrl mic_ctrl_chk #(.NVEC(NVEC)) mic_ctrl_chk_inst (.clk(clk),
    .rstn(rstn), .psel(psel), .penable(penable), .pready(pready),
    .pslverr(pslverr), .paddr(paddr), .prdata(prdata), .irq_req(irq_req),
    .nmi_req(nmi_req), .handler_return_instr(handler_return_instr),
    .irq_ack(irq_ack), .irq_vector(irq_vector), .level_status(level_status));
`default_nettype wire

// ===== test/tb.sv
// Purpose: self-checking bench for the interrupt controller
// Assumes: cpu model answers acks; bench plays peripherals and software
// Notes:   outputs are sampled on the falling edge, apb read data on the rising edge
`timescale 1ns/1ps
`default_nettype none
`include "mic_consts.vh"
module tb;
    logic        clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
    logic        global_ie = 1, ret_go = 0, se, cpu_ready, hret, pready;
    logic        pslverr, irq_ack, vector_location;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd, irq_req = 0, nmi_req = 0;
    logic [63:0] irq_level = 0;
    logic [7:0]  irq_vector, level_status;
    int          err_total = 0, check_count = 0, cyc = 0;
    mic_ctrl #(.NVEC(32)) mic_ctrl_inst (.clk(clk), .rstn(rstn),
        .clk_en(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq_req(irq_req), .irq_level(irq_level),
        .nmi_req(nmi_req), .global_ie(global_ie), .cpu_ready(cpu_ready),
        .handler_return_instr(hret), .irq_ack(irq_ack),
        .irq_vector(irq_vector), .vector_location(vector_location),
        .level_status(level_status));
    mic_cpu_model mic_cpu_model_inst (.clk(clk), .rstn(rstn),
        .irq_ack(irq_ack), .ret_go(ret_go), .cpu_ready(cpu_ready),
        .handler_return_instr(hret));
    initial forever #2 clk = ~clk;
    // cut a hung run short
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            give_verdict();
        end
    end
    task automatic chk(input string n, input logic [31:0] e, g);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    // one apb transfer, held until pready is seen
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n = 0;
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        // hold the request until pready is sampled high at a rising edge
        do @(posedge clk); while (pready !== 1'b1 && ++n < 20);
        rd = prdata;
        se = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    // wait for an acknowledge, then the peripheral drops its request
    task automatic wait_ack(input int v);
        int n = 0;
        do @(negedge clk); while (irq_ack !== 1'b1 && ++n < 200);
        chk("irq_ack", 1, irq_ack);
        chk("irq_vector", v, irq_vector);
        @(posedge clk);
        irq_req[v] <= 1'b0;
        nmi_req[v] <= 1'b0;
        @(negedge clk);
    endtask
    task automatic ret;
        @(posedge clk);
        ret_go <= 1'b1;
        @(posedge clk);
        ret_go <= 1'b0;
    endtask
    task automatic req(input int v, input logic [1:0] l);
        irq_req[v] <= 1'b1;
        irq_level[2*v+:2] <= l;
    endtask
    task automatic t_regs;
        apb(0, `MIC_ADDR_STATUS, 32'h0);
        chk("status", 0, rd);
        apb(0, `MIC_ADDR_LASTVEC, 32'h0);
        chk("last_vector", 0, rd);
        apb(0, `MIC_ADDR_CTRL, 32'h0);
        chk("control", 0, rd);
        apb(1, 12'h010, 32'h1);
        chk("pslverr", 1, se);
        apb(1, `MIC_ADDR_CTRL, 32'h40);
        repeat (2) @(negedge clk);
        chk("vector_location", 0, vector_location);
        apb(1, `MIC_ADDR_CCP, `MIC_CCP_KEY);
        apb(1, `MIC_ADDR_CTRL, 32'h47);
        repeat (2) @(negedge clk);
        chk("vector_location", 1, vector_location);
    endtask
    task automatic t_levels;
        req(6, 2'h1);
        req(4, 2'h1);
        wait_ack(4);
        req(9, 2'h3);
        req(2, 2'h2);
        wait_ack(9);
        chk("level_status", 8'h05, level_status);
        ret();
        wait_ack(2);
        chk("level_status", 8'h03, level_status);
        ret();
        repeat (4) @(negedge clk);
        chk("level_status", 8'h01, level_status);
        ret();
        wait_ack(6);
        ret();
    endtask
    task automatic t_nmi;
        req(1, 2'h3);
        wait_ack(1);
        global_ie <= 1'b0;
        nmi_req[6] <= 1'b1;
        wait_ack(6);
        chk("level_status", 8'h84, level_status);
        nmi_req[7] <= 1'b1;
        repeat (20) @(negedge clk);
        ret();
        wait_ack(7);
        ret();
        repeat (4) @(negedge clk);
        chk("level_status", 8'h04, level_status);
        ret();
        global_ie <= 1'b1;
    endtask
    task automatic t_enable;
        int last = 7;
        for (int l = 0; l < 4; l++) begin
            apb(1, `MIC_ADDR_CTRL, l ? 32'h7 ^ (1 << (l - 1)) : 32'h7);
            req(10 + l, l[1:0]);
            repeat (30) @(negedge clk);
            chk("irq_vector", last, irq_vector);
            apb(1, `MIC_ADDR_CTRL, 32'h7);
            if (l > 0) begin
                wait_ack(10 + l);
                ret();
                last = 10 + l;
            end else begin
                irq_req[10] <= 1'b0;
            end
        end
    endtask
    task automatic t_rotate;
        apb(1, `MIC_ADDR_CTRL, 32'h87);
        req(2, 2'h1);
        req(7, 2'h1);
        wait_ack(2);
        apb(0, `MIC_ADDR_LASTVEC, 32'h0);
        chk("last_vector", 2, rd);
        req(2, 2'h1);
        ret();
        wait_ack(7);
        ret();
        wait_ack(2);
        ret();
        apb(1, `MIC_ADDR_CTRL, 32'h7);
        apb(0, `MIC_ADDR_LASTVEC, 32'h0);
        chk("last_vector", 2, rd);
    endtask
    task automatic give_verdict;
        if (err_total == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        t_regs();
        t_levels();
        t_nmi();
        t_enable();
        t_rotate();
        give_verdict();
    end
endmodule
`default_nettype wire
